// ### cic_pkg.sv
// Purpose: Shared constants and types for the cascaded interrupt controller pair.
// Assumes: Byte-wide I/O cycles on an 8-bit address space.
// Notes: Trigger select ports sit at offsets picked for this block.
package cic_pkg;
    localparam logic [7:0] MASTER_BASE = 8'h20;
    localparam logic [7:0] MASTER_DATA = 8'h21;
    localparam logic [7:0] SLAVE_BASE = 8'ha0;
    localparam logic [7:0] SLAVE_DATA = 8'ha1;
    localparam logic [7:0] MASTER_TRIG = 8'hd0;
    localparam logic [7:0] SLAVE_TRIG = 8'hd1;
    localparam int INIT_BIT = 4;
    localparam int MODE_AUTO_EOI = 1;
    localparam int CASCADE_LINE = 2;
    localparam logic [7:0] MASTER_CASCADE_RST = 8'h04;
    localparam logic [7:0] TRIG_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [2:0] ID_RST = 3'h0;
    localparam logic [4:0] VEC_RST = 5'h00;

    // Initialization sequence: Gray coded along the usual path.
    typedef enum logic [1:0] {
        CIC_READY = 2'b00,
        CIC_WAIT_VEC = 2'b01,
        CIC_WAIT_CAS = 2'b11,
        CIC_WAIT_MODE = 2'b10
    } cic_init_e;

    // One host I/O cycle.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } cic_io_s;
endpackage

// ### cic_ctrl.sv
// Purpose: Configuration, masking, triggering and cascade identification for a master/slave controller pair.
// Assumes: Inputs synchronous to clk_sys; requests active high.
// Notes: Priority resolution and end-of-interrupt commands live outside this block.
`timescale 1ns/1ps

// ----------------------------------------
// Controller pair
// ----------------------------------------
// How it works
// - Init bit on base starts three-word sequence.
// - Cascade id driven between acknowledge pulse ends.
// - Mode bit one enables automatic end-of-interrupt.
// - Mask bit one blocks line; readable.
// - Mask writes accepted whenever no init sequence is running.
// - Masking master line two blocks slave.
// - Per-channel trigger select, resets to edge.
// - Master cascade word resets to bit two.
module cic_ctrl #(
    parameter int LINES = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire cic_pkg::cic_io_s io_req,
    output logic [7:0] io_rdata,
    output logic io_rvalid,
    input wire logic [LINES-1:0] master_irq_in,
    input wire logic [LINES-1:0] slave_irq_in,
    input wire logic irq_ack_strobe_n,
    output logic [LINES-1:0] master_pending,
    output logic [LINES-1:0] slave_pending,
    output logic slave_int,
    output logic master_int,
    output logic [2:0] cascade_id_code,
    output logic cascade_id_oe,
    output logic master_auto_eoi,
    output logic slave_auto_eoi,
    input wire logic [LINES-1:0] master_clear,
    input wire logic [LINES-1:0] slave_clear
);
    // ----------------------------------------
    // Overview
    // ----------------------------------------
    // Each controller owns a base port and a data port. A base-port write with the init
    // bit set starts a sequence in which the next three data-port writes fill the vector,
    // cascade and mode words, in that order; only after the mode word does the data port
    // reach the line mask again. A new init may start at any point and restarts the count.
    //
    // Requests pass a trigger stage and then the mask to form the pending lines. Edge
    // channels keep a latch that only a clear pulse drops; level channels follow the pin.
    // The slave's combined output enters the master on the lines that the master cascade
    // word names, which is line two out of reset.
    //
    // Priority resolution and end-of-interrupt clearing sit outside this block and feed
    // back through the clear inputs. A clear and a new rising edge on one line in the same
    // cycle keep the request, so an edge that arrives in the very cycle of the old one's clear
    // is never lost.
    //
    // During an acknowledge the slave's identity code is put out from the end of the first
    // strobe pulse to the end of the second, changing on the first clock that sees each edge.
    //
    // Limitation: the vector word and the upper mode bits are stored but not used here.
    //
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // Per-controller state, index 0 master, 1 slave.
    cic_pkg::cic_init_e state_ff [2];
    cic_pkg::cic_init_e nxt_state [2];
    logic [7:0] line_mask_bits_ff [2];
    logic [7:0] trig_ff [2];
    logic [7:0] cascade_config_word_ff [2];
    logic [4:0] vector_base_word_ff [2];
    logic [7:0] mode_ff [2];
    logic [LINES-1:0] edge_latch_ff [2];
    logic [LINES-1:0] irq_prev_ff [2];
    logic [LINES-1:0] irq_in [2];
    logic [LINES-1:0] clr_in [2];
    logic [LINES-1:0] pend [2];
    logic base_hit [2];
    logic data_hit [2];
    logic trig_hit [2];
    logic [1:0] ack_cnt_ff;
    logic ack_prev_ff;
    logic [7:0] nxt_rdata;
    logic rd_hit;
    logic [LINES-1:0] cascade_route;
    logic ack_trail;

    // ----------------------------------------
    // Request inputs
    // ----------------------------------------
    // Requests and clears in array form, so that one loop serves both controllers.
    assign irq_in[0] = master_irq_in;
    assign irq_in[1] = slave_irq_in;
    assign clr_in[0] = master_clear;
    assign clr_in[1] = slave_clear;

    // ----------------------------------------
    // Port decode
    // ----------------------------------------
    // Address decode for each controller.
    assign base_hit[0] = io_req.wr && (io_req.addr == cic_pkg::MASTER_BASE);
    assign base_hit[1] = io_req.wr && (io_req.addr == cic_pkg::SLAVE_BASE);
    assign data_hit[0] = io_req.wr && (io_req.addr == cic_pkg::MASTER_DATA);
    assign data_hit[1] = io_req.wr && (io_req.addr == cic_pkg::SLAVE_DATA);
    assign trig_hit[0] = io_req.wr && (io_req.addr == cic_pkg::MASTER_TRIG);
    assign trig_hit[1] = io_req.wr && (io_req.addr == cic_pkg::SLAVE_TRIG);

    // ----------------------------------------
    // Per-controller configuration and requests
    // ----------------------------------------
    // Index 0 is the master and index 1 the slave; the two copies differ only in their
    // reset values and in the ports that the decode above routes to them.
    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : g_ctl
            logic start_init;
            logic vec_wr;
            logic cas_wr;
            logic mode_wr;
            logic mask_wr;
            logic [LINES-1:0] rise;
            logic [LINES-1:0] edge_sel;
            logic [LINES-1:0] level_sel;
            logic [LINES-1:0] line_open;

            // A base-port write with the init bit set restarts the sequence from any state.
            assign start_init = base_hit[c] && io_req.data[cic_pkg::INIT_BIT];

            // Data-port writes are steered by the sequence position. Until the mode word
            // lands the data port never reaches the mask, so an init that the host abandons
            // half way cannot mask lines by accident.
            assign vec_wr = data_hit[c] && (state_ff[c] == cic_pkg::CIC_WAIT_VEC);
            assign cas_wr = data_hit[c] && (state_ff[c] == cic_pkg::CIC_WAIT_CAS);
            assign mode_wr = data_hit[c] && (state_ff[c] == cic_pkg::CIC_WAIT_MODE);
            assign mask_wr = data_hit[c] && (state_ff[c] == cic_pkg::CIC_READY);

            // Initialization sequence steps through three data-port writes.
            always_comb begin
                nxt_state[c] = state_ff[c];
                if (start_init) begin
                    nxt_state[c] = cic_pkg::CIC_WAIT_VEC;
                end else if (data_hit[c]) begin
                    case (state_ff[c])
                        cic_pkg::CIC_WAIT_VEC: nxt_state[c] = cic_pkg::CIC_WAIT_CAS;
                        cic_pkg::CIC_WAIT_CAS: nxt_state[c] = cic_pkg::CIC_WAIT_MODE;
                        cic_pkg::CIC_WAIT_MODE: nxt_state[c] = cic_pkg::CIC_READY;
                        default: nxt_state[c] = cic_pkg::CIC_READY;
                    endcase
                end
            end

            // Sequence position.
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    state_ff[c] <= cic_pkg::CIC_READY;
                end else begin
                    state_ff[c] <= nxt_state[c];
                end
            end

            // Vector base word: only the upper five bits are stored.
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    vector_base_word_ff[c] <= cic_pkg::VEC_RST;
                end else if (vec_wr) begin
                    vector_base_word_ff[c] <= io_req.data[7:3];
                end
            end

            // Cascade word: the master leaves reset already wired to line two.
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    cascade_config_word_ff[c] <= (c == 0) ? cic_pkg::MASTER_CASCADE_RST
                                                          : cic_pkg::ZERO_BYTE;
                end else if (cas_wr) begin
                    cascade_config_word_ff[c] <= io_req.data;
                end
            end

            // Mode word; only the automatic end-of-interrupt bit acts inside this block.
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    mode_ff[c] <= cic_pkg::ZERO_BYTE;
                end else if (mode_wr) begin
                    mode_ff[c] <= io_req.data;
                end
            end

            // Line mask: a write sets every bit at once, so each line follows its own bit.
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    line_mask_bits_ff[c] <= cic_pkg::MASK_RST;
                end else if (mask_wr) begin
                    line_mask_bits_ff[c] <= io_req.data;
                end
            end

            // Trigger select stays writable at all times, also in the middle of an init.
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    trig_ff[c] <= cic_pkg::TRIG_RST;
                end else if (trig_hit[c]) begin
                    trig_ff[c] <= io_req.data;
                end
            end

            // Edge channels latch a rising input; a clear never beats a new edge.
            assign rise = irq_in[c] & ~irq_prev_ff[c];
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    irq_prev_ff[c] <= '0;
                    edge_latch_ff[c] <= '0;
                end else begin
                    irq_prev_ff[c] <= irq_in[c];
                    edge_latch_ff[c] <= (edge_latch_ff[c] & ~clr_in[c]) | rise;
                end
            end

            // Edge channels show their latch and level channels the live input.
            assign edge_sel = edge_latch_ff[c] & ~trig_ff[c][LINES-1:0];
            assign level_sel = irq_in[c] & trig_ff[c][LINES-1:0];
            // A masked line is held off whatever its trigger kind.
            assign line_open = ~line_mask_bits_ff[c][LINES-1:0];
            assign pend[c] = (edge_sel | level_sel) & line_open;
        end
    endgenerate

    // ----------------------------------------
    // Cascade into the master
    // ----------------------------------------
    // The slave output enters the master on the lines that the master's cascade word names,
    // so the master mask on those lines gates every slave request as well.
    assign slave_int = |pend[1];
    assign slave_pending = pend[1];
    assign cascade_route = {LINES{slave_int}} & cascade_config_word_ff[0][LINES-1:0];
    assign master_pending = pend[0] | (cascade_route & ~line_mask_bits_ff[0][LINES-1:0]);
    assign master_int = |master_pending;
    assign master_auto_eoi = mode_ff[0][cic_pkg::MODE_AUTO_EOI];
    assign slave_auto_eoi = mode_ff[1][cic_pkg::MODE_AUTO_EOI];

    // ----------------------------------------
    // Acknowledge sequence
    // ----------------------------------------
    // The pulse counter toggles on every trailing edge of the strobe. Its history starts
    // high, the idle level of the strobe, so the release of reset is never taken for an edge.
    assign ack_trail = irq_ack_strobe_n && !ack_prev_ff;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ack_prev_ff <= 1'b1;
            ack_cnt_ff <= 2'h0;
        end else begin
            ack_prev_ff <= irq_ack_strobe_n;
            if (ack_trail) begin
                ack_cnt_ff <= (ack_cnt_ff == 2'h1) ? 2'h0 : 2'h1;
            end
        end
    end
    // The code is driven only while master line two carries a pending request.
    assign cascade_id_oe = (ack_cnt_ff == 2'h1) && master_pending[cic_pkg::CASCADE_LINE];
    assign cascade_id_code = cascade_id_oe ? cascade_config_word_ff[1][2:0] : cic_pkg::ID_RST;

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Masks and trigger selects read back one cycle after the strobe. Unmapped reads answer
    // with zero data and no valid flag, and data is forced to zero between reads so that a
    // stale byte never lingers on the bus.
    // Read data: masks and trigger selects, registered.
    assign rd_hit = io_req.rd && ((io_req.addr == cic_pkg::MASTER_DATA) || (io_req.addr == cic_pkg::SLAVE_DATA)
                    || (io_req.addr == cic_pkg::MASTER_TRIG) || (io_req.addr == cic_pkg::SLAVE_TRIG));
    always_comb begin
        if (io_req.addr == cic_pkg::MASTER_DATA) begin
            nxt_rdata = line_mask_bits_ff[0];
        end else if (io_req.addr == cic_pkg::SLAVE_DATA) begin
            nxt_rdata = line_mask_bits_ff[1];
        end else if (io_req.addr == cic_pkg::MASTER_TRIG) begin
            nxt_rdata = trig_ff[0];
        end else if (io_req.addr == cic_pkg::SLAVE_TRIG) begin
            nxt_rdata = trig_ff[1];
        end else begin
            nxt_rdata = cic_pkg::ZERO_BYTE;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            io_rdata <= cic_pkg::ZERO_BYTE;
            io_rvalid <= 1'b0;
        end else begin
            io_rdata <= io_req.rd ? nxt_rdata : cic_pkg::ZERO_BYTE;
            io_rvalid <= rd_hit;
        end
    end
endmodule

// ### cic_ctrl_sva.sv
// Purpose: Port checks for the controller pair.
// Assumes: Bound onto every cic_ctrl.
// Notes: Mask state is internal, so mask effects are judged by the bench.
`timescale 1ns/1ps
module cic_ctrl_sva #(
    parameter int LINES = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire cic_pkg::cic_io_s io_req,
    input wire logic [7:0] io_rdata,
    input wire logic io_rvalid,
    input wire logic irq_ack_strobe_n,
    input wire logic [LINES-1:0] master_pending,
    input wire logic [LINES-1:0] slave_pending,
    input wire logic slave_int,
    input wire logic master_int,
    input wire logic [2:0] cascade_id_code,
    input wire logic cascade_id_oe,
    input wire logic master_auto_eoi
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Trailing edge of one acknowledge pulse.
    sequence s_ack_end;
        !irq_ack_strobe_n ##1 irq_ack_strobe_n;
    endsequence
    a_slave_int_or: assert property (slave_int == |slave_pending) else $error("slave_int wrong");
    a_master_int_or: assert property (master_int == |master_pending) else $error("master_int wrong");
    a_rvalid_after_rd: assert property (io_rvalid |-> $past(io_req.rd)) else $error("stray rvalid");
    a_rdata_idle: assert property (!io_rvalid |-> io_rdata == 8'h00) else $error("stray rdata");
    a_id_quiet: assert property (!cascade_id_oe |-> cascade_id_code == 3'h0) else $error("id leak");
    a_id_start: assert property ($rose(cascade_id_oe) |-> $past(irq_ack_strobe_n) && !$past(irq_ack_strobe_n, 2))
        else $error("id early");
    a_id_end: assert property ($fell(cascade_id_oe) |-> irq_ack_strobe_n) else $error("id cut short");
    a_eoi_by_write: assert property ($changed(master_auto_eoi) |-> $past(io_req.wr)) else $error("eoi moved");
    // The cascade code appears once a first pulse has ended.
    c_id_seen: cover property (s_ack_end ##1 cascade_id_oe);
endmodule
bind cic_ctrl cic_ctrl_sva #(.LINES(LINES)) i_sva (.clk_sys, .sys_rst, .io_req, .io_rdata, .io_rvalid,
    .irq_ack_strobe_n, .master_pending, .slave_pending, .slave_int, .master_int, .cascade_id_code,
    .cascade_id_oe, .master_auto_eoi);

// ### cic_host.sv
// Purpose: Host processor model issuing I/O cycles and acknowledges.
// Assumes: Inputs change 5 ns after the rising edge.
// Notes: Released address and data lines carry the inverse of the last value.
`timescale 1ns/1ps
module cic_host (
    input wire logic clk_sys,
    input wire logic [7:0] io_rdata,
    input wire logic io_rvalid,
    output cic_pkg::cic_io_s io_req,
    output logic irq_ack_strobe_n
);
    // Idle bus at time zero.
    initial begin
        io_req = '0;
        irq_ack_strobe_n = 1'b1;
    end
    // One cycle strobe, then the answer is taken a cycle later.
    task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic v);
        @(posedge clk_sys) #5 io_req <= '{w, !w, a, d};
        @(posedge clk_sys) #5 io_req <= '{1'b0, 1'b0, ~a, ~d};
        q = io_rdata;
        v = io_rvalid;
    endtask
    // Plain write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic v;
        cyc(1'b1, a, d, q, v);
    endtask
    // Start word, then vector, cascade and mode words on the data port.
    task automatic init(input logic [7:0] base, input logic [7:0] cas, input logic [7:0] mode);
        wr(base, 8'h11);
        wr(base + 8'h01, 8'h08);
        wr(base + 8'h01, cas);
        wr(base + 8'h01, mode);
    endtask
    // One acknowledge pulse, low for two cycles.
    task automatic ack_pulse();
        @(posedge clk_sys) #5 irq_ack_strobe_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #5 irq_ack_strobe_n <= 1'b1;
    endtask
endmodule

// ### tb_top.sv
// Purpose: Self-checking bench for the controller pair.
// Assumes: Trigger ports at the package offsets.
// Notes: Line two of the master is left to the cascade.
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    cic_pkg::cic_io_s io_req;
    logic [7:0] io_rdata, mp, sp, mi, si, mc, sc, q, m, r;
    logic io_rvalid, ack_n, master_int, slave_int, oe, meoi, seoi, v;
    logic [2:0] id;
    logic [31:0] seed = 32'h03f8;
    int fails = 0;
    int compares = 0;
    always #25 clk_sys = ~clk_sys;
    cic_ctrl i_dut (.clk_sys, .sys_rst, .io_req, .io_rdata, .io_rvalid, .master_irq_in(mi), .slave_irq_in(si),
        .irq_ack_strobe_n(ack_n), .master_pending(mp), .slave_pending(sp), .slave_int, .master_int,
        .cascade_id_code(id), .cascade_id_oe(oe), .master_auto_eoi(meoi), .slave_auto_eoi(seoi),
        .master_clear(mc), .slave_clear(sc));
    cic_host i_host (.clk_sys, .io_rdata, .io_rvalid, .io_req, .irq_ack_strobe_n(ack_n));
    // Random source and expected pending lines.
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] seen(input logic [7:0] req, input logic [7:0] mask);
        return req & ~mask;
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic ev);
        i_host.cyc(1'b0, a, 8'h00, q, v);
        chk("rvalid", {7'h0, ev}, {7'h0, v});
        chk("rdata", e, q);
    endtask
    task automatic tick();
        @(posedge clk_sys);
        #5;
    endtask
    task automatic results();
        if (fails == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Hang guard.
    initial begin
        #2000000;
        fails++;
        results();
    end
    // Main sequence.
    initial begin
        {mi, si, mc, sc} = '0;
        repeat (20) @(posedge clk_sys);
        #5 sys_rst = 1'b0;
        rd(cic_pkg::MASTER_DATA, cic_pkg::MASK_RST, 1'b1);
        rd(cic_pkg::MASTER_TRIG, cic_pkg::TRIG_RST, 1'b1);
        rd(8'h55, 8'h00, 1'b0);
        // Before any init the slave must already reach master line two.
        i_host.wr(cic_pkg::MASTER_DATA, 8'h00);
        i_host.wr(cic_pkg::SLAVE_DATA, 8'h00);
        si = 8'h01;
        tick();
        chk("reset_cascade", 8'h04, mp);
        {si, sc} = {8'h00, 8'hff};
        tick();
        sc = 8'h00;
        chk("slave_cleared", 8'h00, sp);
        i_host.init(cic_pkg::MASTER_BASE, 8'h04, 8'h03);
        i_host.init(cic_pkg::SLAVE_BASE, 8'h02, 8'h01);
        chk("auto_eoi", 8'h02, {6'h0, meoi, seoi});
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            {m, r} = (i < 2) ? {{8{i[0]}}, 8'hfb} : {seed[7:0], seed[15:8] & 8'hfb};
            i_host.wr(cic_pkg::MASTER_DATA, m);
            rd(cic_pkg::MASTER_DATA, m, 1'b1);
            // Odd rounds clear in the same cycle as the new edge; the edge must win.
            {mi, mc} = {r, {8{i[0]}}};
            tick();
            chk("edge_pending", seen(r, m), mp);
            {mi, mc} = {8'h00, 8'hff};
            tick();
            mc = 8'h00;
            chk("edge_cleared", 8'h00, mp);
        end
        i_host.wr(cic_pkg::MASTER_DATA, 8'h00);
        i_host.wr(cic_pkg::MASTER_TRIG, 8'hf8);
        rd(cic_pkg::MASTER_TRIG, 8'hf8, 1'b1);
        mi = 8'h18;
        tick();
        chk("level_pending", 8'h18, mp);
        mi = 8'h00;
        tick();
        chk("level_dropped", 8'h00, mp);
        i_host.wr(cic_pkg::MASTER_DATA, 8'h04);
        i_host.wr(cic_pkg::SLAVE_DATA, 8'h00);
        si = 8'h08;
        tick();
        chk("slave_pending", 8'h08, sp);
        chk("slave_int", 8'h01, {7'h0, slave_int});
        chk("master_blocked", 8'h00, mp | {7'h0, master_int});
        i_host.wr(cic_pkg::MASTER_DATA, 8'h00);
        chk("master_cascade", 8'h04, mp);
        i_host.ack_pulse();
        tick();
        chk("cascade_id", 8'h0a, {4'h0, oe, id});
        i_host.ack_pulse();
        tick();
        chk("cascade_quiet", 8'h00, {4'h0, oe, id});
        {si, sc} = {8'h00, 8'hff};
        tick();
        sc = 8'h00;
        chk("slave_dropped", 8'h00, sp);
        chk("master_idle", 8'h00, mp | {7'h0, master_int});
        results();
    end
endmodule
